// ==== logic/rwr_pkg.sv ====
/* rwr_pkg: register map, field positions, reset values and state types of
   the calendar output and wakeup block.
   assumes a 32-bit APB master and a 40 MHz core clock.
*/
// Operation
// - select zero and cal enable drive calibrated clock, 512 Hz or 1 Hz
// - select one outputs alarm A event, select three outputs wakeup event
// - event sources honour open-drain or push-pull and active level choice
// - alarm, wakeup timer, stamp and tamper events can each raise wakeup
// - on high-speed external oscillator events wake only from Sleep
// - on low-speed clocks events wake from Sleep, Deepsleep and Standby
// - events set own flags; enabled ones drive lines 17, 20 and 19
// - reset values: date 2101, status 7, divider, reload, stamp date D
// - time bit 22 is half-day flag, zero in 24-hour format
// - select 00 off, 01 alarm A, 10 alarm B, 11 wakeup; polarity 1 low
`default_nettype none
package rwr_pkg;
    localparam logic [7:0] OFF_TIME = 8'h00;
    localparam logic [7:0] OFF_DATE = 8'h04;
    localparam logic [7:0] OFF_CTRL = 8'h08;
    localparam logic [7:0] OFF_STS = 8'h0C;
    localparam logic [7:0] OFF_DIV = 8'h10;
    localparam logic [7:0] OFF_WAT = 8'h14;
    localparam logic [7:0] OFF_ALA = 8'h1C;
    localparam logic [7:0] OFF_WP = 8'h24;
    localparam logic [7:0] OFF_SBS = 8'h28;
    localparam logic [7:0] OFF_TADJ = 8'h2C;
    localparam logic [7:0] OFF_TSTM = 8'h30;
    localparam logic [7:0] OFF_TSDT = 8'h34;
    localparam logic [7:0] OFF_TSSBS = 8'h38;
    localparam logic [7:0] OFF_SCAL = 8'h3C;
    localparam logic [7:0] OFF_TAMP = 8'h40;
    localparam logic [7:0] OFF_ALASBS = 8'h44;
    localparam logic [7:0] OFF_BKP_FIRST = 8'h50;
    localparam logic [7:0] OFF_BKP_LAST = 8'h60;
    localparam logic [7:0] OFF_MASK = 8'h70;
    localparam int BKP_WORDS = 5;

    localparam logic [31:0] RST_DATE = 32'h0000_2101;
    localparam logic [31:0] RST_STS = 32'h0000_0007;
    localparam logic [31:0] RST_DIV = 32'h007F_00FF;
    localparam logic [31:0] RST_WAT = 32'h0000_FFFF;
    localparam logic [31:0] RST_TSDT = 32'h0000_000D;

    localparam logic [31:0] TIME_WMASK = 32'h007F_7F7F;
    localparam logic [31:0] DATE_WMASK = 32'h00FF_FF3F;
    localparam logic [31:0] CTRL_WMASK = 32'h00FC_DD7F;

    localparam int CTL_CAL_OUT_EN = 23;
    localparam int CTL_SRC_LO = 21;
    localparam int CTL_POL = 20;
    localparam int CTL_CAL_RATE = 19;
    localparam int CTL_STAMP_IE = 15;
    localparam int CTL_WAKE_IE = 14;
    localparam int CTL_ALARM_IE = 12;
    localparam int CTL_HOUR_MODE = 6;
    localparam int TAMP_IE = 2;
    localparam int TAMP_ODRAIN = 18;
    localparam int TIME_HALF_DAY = 22;
    localparam int DATE_WDAY_LO = 13;

    localparam int STS_ALARM = 8;
    localparam int STS_WAKE = 10;
    localparam int STS_STAMP = 11;
    localparam int STS_TAMPER = 13;
    localparam int FLG_ALARM = 0;
    localparam int FLG_WAKE = 1;
    localparam int FLG_STAMP = 2;
    localparam int FLG_TAMPER = 3;

    localparam logic [1:0] SRC_OFF = 2'h0;
    localparam logic [1:0] SRC_ALARM_A = 2'h1;
    localparam logic [1:0] SRC_ALARM_B = 2'h2;
    localparam logic [1:0] SRC_WAKE = 2'h3;

    localparam logic [1:0] CS_NONE = 2'h0;
    localparam logic [1:0] CS_LS_XTAL = 2'h1;
    localparam logic [1:0] CS_LS_RC = 2'h2;
    localparam logic [1:0] CS_HS_OSC = 2'h3;

    localparam int CORE_CLK_HZ = 40_000_000;
    localparam int CAL_FAST_HZ = 512;
    localparam int CAL_SLOW_HZ = 1;
    localparam int CAL_FAST_HALF = CORE_CLK_HZ / (2 * CAL_FAST_HZ);
    localparam int CAL_SLOW_HALF = CORE_CLK_HZ / (2 * CAL_SLOW_HZ);
    localparam int CAL_CNT_W = 25;

    function automatic logic [31:0] flags_to_word(input logic [3:0] f);
        flags_to_word = '0;
        flags_to_word[STS_ALARM] = f[FLG_ALARM];
        flags_to_word[STS_WAKE] = f[FLG_WAKE];
        flags_to_word[STS_STAMP] = f[FLG_STAMP];
        flags_to_word[STS_TAMPER] = f[FLG_TAMPER];
    endfunction

    function automatic logic [3:0] word_to_flags(input logic [31:0] w);
        word_to_flags = {w[STS_TAMPER], w[STS_STAMP], w[STS_WAKE],
                         w[STS_ALARM]};
    endfunction

    typedef struct packed {
        logic [31:0] tim;
        logic [31:0] date;
        logic [31:0] ctrl;
        logic [31:0] div;
        logic [31:0] wat;
        logic [31:0] ala;
        logic [31:0] wp;
        logic [31:0] sbs;
        logic [31:0] tadj;
        logic [31:0] tstm;
        logic [31:0] tsdt;
        logic [31:0] tssbs;
        logic [31:0] scal;
        logic [31:0] tamp;
        logic [31:0] alasbs;
        logic [BKP_WORDS-1:0][31:0] bkp;
        logic [3:0] flg;
        logic [3:0] msk;
        logic [31:0] rdata;
        logic slverr;
        logic l17;
        logic l19;
        logic l20;
        logic wk_sleep;
        logic wk_low;
        logic irq;
    } rwr_regs_t;

    localparam rwr_regs_t REGS_RST = '{date: RST_DATE, div: RST_DIV,
        wat: RST_WAT, tsdt: RST_TSDT, default: '0};

    typedef struct packed {
        logic [CAL_CNT_W-1:0] cnt;
        logic clk_lvl;
        logic pin;
        logic oe;
    } rwr_mux_t;
endpackage
`default_nettype wire

// ==== logic/rwr_out_if.sv ====
/* rwr_out_if: settings and event levels passed from the register file to
   the output pin multiplexer.
   assumes both ends sit on the same core clock.
*/
`default_nettype none
interface rwr_out_if;
    logic [1:0] src_sel;
    logic cal_en;
    logic cal_rate;
    logic pol;
    logic odrain;
    logic alarm_lvl;
    logic wake_lvl;
    modport src (output src_sel, cal_en, cal_rate, pol, odrain,
                 alarm_lvl, wake_lvl);
    modport sink (input src_sel, cal_en, cal_rate, pol, odrain,
                  alarm_lvl, wake_lvl);
endinterface
`default_nettype wire

// ==== logic/rwr_out_mux.sv ====
/* rwr_out_mux: multiplexed event output pin with calibrated clock divider,
   drive type and polarity.
   assumes settings come from flops in the register file.
*/
`default_nettype none
module rwr_out_mux import rwr_pkg::*; #(
    parameter logic [CAL_CNT_W-1:0] FAST_HALF = CAL_CNT_W'(CAL_FAST_HALF),
    parameter logic [CAL_CNT_W-1:0] SLOW_HALF = CAL_CNT_W'(CAL_SLOW_HALF)
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    rwr_out_if.sink oif,
    output logic pin_o,
    output logic pin_oe
);
    rwr_mux_t q;
    rwr_mux_t nx;
    logic [CAL_CNT_W-1:0] half;
    logic run;
    logic act;

    always_comb begin
        nx = q;
        half = oif.cal_rate ? SLOW_HALF : FAST_HALF;
        run = (oif.src_sel == SRC_OFF) && oif.cal_en;
        // divider is held cleared while unused so a restart is clean
        if (!run) begin
            nx.cnt = '0;
            nx.clk_lvl = 1'b0;
        end else if (q.cnt >= half - CAL_CNT_W'(1)) begin
            nx.cnt = '0;
            nx.clk_lvl = !q.clk_lvl;
        end else begin
            nx.cnt = q.cnt + CAL_CNT_W'(1);
        end
        case (oif.src_sel)
            SRC_ALARM_A: act = oif.alarm_lvl ^ oif.pol;
            SRC_WAKE: act = oif.wake_lvl ^ oif.pol;
            default: act = oif.pol;
        endcase
        if (oif.src_sel != SRC_OFF) begin
            nx.pin = oif.odrain ? 1'b0 : act;
            nx.oe = oif.odrain ? !act : 1'b1;
        end else begin
            nx.pin = nx.clk_lvl;
            nx.oe = run;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= nx;
        end
    end

    assign pin_o = q.pin;
    assign pin_oe = q.oe;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    property p_cal_toggle;
        run && q.cnt == half - CAL_CNT_W'(1) |=> q.clk_lvl != $past(q.clk_lvl);
    endproperty
    a_cal_toggle: assert property (p_cal_toggle)
        else $error("calibrated clock did not toggle at half period");

    property p_alarm_out;
        oif.src_sel == SRC_ALARM_A && !oif.odrain
            |=> pin_oe && pin_o == $past(oif.alarm_lvl ^ oif.pol);
    endproperty
    a_alarm_out: assert property (p_alarm_out)
        else $error("alarm A level not on output");

    property p_odrain;
        oif.src_sel == SRC_WAKE && oif.odrain
            |=> !pin_o && pin_oe == ($past(oif.wake_lvl) == $past(oif.pol));
    endproperty
    a_odrain: assert property (p_odrain)
        else $error("open-drain wakeup output wrong");

    property p_alarm_b;
        oif.src_sel == SRC_ALARM_B && !oif.odrain |=> pin_o == $past(oif.pol);
    endproperty
    a_alarm_b: assert property (p_alarm_b)
        else $error("unused alarm B select not at inactive level");
endmodule
`default_nettype wire

// ==== logic/rwr_top.sv ====
/* rwr_top: APB register file of the calendar clock with event flags,
   interrupt lines, low-power wake requests and the multiplexed output pin.
   assumes event inputs are one-cycle pulses from the calendar core and
   clk_src names the clock that runs the calendar.
*/
// Added by the designer: register access over APB.
`default_nettype none
module rwr_top import rwr_pkg::*; #(
    parameter logic [CAL_CNT_W-1:0] FAST_HALF = CAL_CNT_W'(CAL_FAST_HALF),
    parameter logic [CAL_CNT_W-1:0] SLOW_HALF = CAL_CNT_W'(CAL_SLOW_HALF)
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic alarm_a_evt,
    input wire logic wakeup_evt,
    input wire logic stamp_evt,
    input wire logic tamper_evt,
    input wire logic [1:0] clk_src,
    output logic mux_out,
    output logic mux_out_oe,
    output logic external_interrupt_line_line17,
    output logic external_interrupt_line_line19,
    output logic external_interrupt_line_line20,
    output logic wake_sleep,
    output logic wake_deepsleep,
    output logic wake_standby,
    output logic irq
);
    rwr_regs_t st_q;
    rwr_regs_t st_d;
    logic [31:0] rv;
    logic hit;
    logic wr;
    logic in_bkp;
    logic [2:0] bidx;
    logic [7:0] boff;
    logic [3:0] clr;
    logic [3:0] ev;
    logic req;

    rwr_out_if oif();

    assign boff = paddr - OFF_BKP_FIRST;
    assign bidx = boff[4:2];
    assign in_bkp = paddr >= OFF_BKP_FIRST && paddr <= OFF_BKP_LAST
        && paddr[1:0] == 2'b00;
    assign ev = {tamper_evt, stamp_evt, wakeup_evt, alarm_a_evt};

    always_comb begin
        st_d = st_q;
        rv = '0;
        hit = 1'b1;
        clr = '0;
        wr = psel && penable && pwrite && !st_q.slverr;
        case (paddr)
            OFF_TIME: rv = st_q.tim;
            OFF_DATE: rv = st_q.date;
            OFF_CTRL: rv = st_q.ctrl;
            OFF_STS: rv = RST_STS | flags_to_word(st_q.flg);
            OFF_DIV: rv = st_q.div;
            OFF_WAT: rv = st_q.wat;
            OFF_ALA: rv = st_q.ala;
            OFF_WP: rv = st_q.wp;
            OFF_SBS: rv = st_q.sbs;
            OFF_TADJ: rv = st_q.tadj;
            OFF_TSTM: rv = st_q.tstm;
            OFF_TSDT: rv = st_q.tsdt;
            OFF_TSSBS: rv = st_q.tssbs;
            OFF_SCAL: rv = st_q.scal;
            OFF_TAMP: rv = st_q.tamp;
            OFF_ALASBS: rv = st_q.alasbs;
            OFF_MASK: rv = flags_to_word(st_q.msk);
            default: begin
                if (in_bkp) begin
                    rv = st_q.bkp[bidx];
                end else begin
                    hit = 1'b0;
                end
            end
        endcase

        // read data and error are fixed in the setup cycle so that the
        // access phase answers at once from flops
        if (psel && !penable) begin
            st_d.rdata = rv;
            st_d.slverr = !hit || (pwrite && pstrb != 4'hF);
        end

        if (wr) begin
            case (paddr)
                OFF_TIME: st_d.tim = pwdata & TIME_WMASK;
                OFF_DATE: begin
                    st_d.date = pwdata & DATE_WMASK;
                    // an illegal weekday leaves the stored one in place
                    if (pwdata[DATE_WDAY_LO +: 3] == 3'h0) begin
                        st_d.date[DATE_WDAY_LO +: 3] =
                            st_q.date[DATE_WDAY_LO +: 3];
                    end
                end
                OFF_CTRL: st_d.ctrl = pwdata & CTRL_WMASK;
                OFF_STS: clr = word_to_flags(pwdata);
                OFF_DIV: st_d.div = pwdata;
                OFF_WAT: st_d.wat = pwdata;
                OFF_ALA: st_d.ala = pwdata;
                OFF_WP: st_d.wp = pwdata;
                OFF_SBS: st_d.sbs = pwdata;
                OFF_TADJ: st_d.tadj = pwdata;
                OFF_TSTM: st_d.tstm = pwdata;
                OFF_TSDT: st_d.tsdt = pwdata;
                OFF_TSSBS: st_d.tssbs = pwdata;
                OFF_SCAL: st_d.scal = pwdata;
                OFF_TAMP: st_d.tamp = pwdata;
                OFF_ALASBS: st_d.alasbs = pwdata;
                OFF_MASK: st_d.msk = word_to_flags(pwdata);
                default: begin
                    if (in_bkp) begin
                        st_d.bkp[bidx] = pwdata;
                    end
                end
            endcase
        end

        // a new event beats a clear in the same cycle
        st_d.flg = (st_q.flg & ~clr) | ev;

        if (!st_d.ctrl[CTL_HOUR_MODE]) begin
            st_d.tim[TIME_HALF_DAY] = 1'b0;
        end

        st_d.l17 = st_d.flg[FLG_ALARM] && st_d.ctrl[CTL_ALARM_IE];
        st_d.l20 = st_d.flg[FLG_WAKE] && st_d.ctrl[CTL_WAKE_IE];
        st_d.l19 = (st_d.flg[FLG_STAMP] && st_d.ctrl[CTL_STAMP_IE])
            || (st_d.flg[FLG_TAMPER] && st_d.tamp[TAMP_IE]);

        req = st_d.l17 || st_d.l19 || st_d.l20;
        // with no calendar clock no event can arrive, so no wake either
        st_d.wk_sleep = req && clk_src != CS_NONE;
        // the fast oscillator stops in deep modes, so it cannot wake them
        st_d.wk_low = req && (clk_src == CS_LS_RC
            || clk_src == CS_LS_XTAL);
        st_d.irq = |(st_d.flg & st_d.msk);
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= REGS_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign pready = psel && penable;
    assign prdata = st_q.rdata;
    assign pslverr = st_q.slverr && psel && penable;
    assign external_interrupt_line_line17 = st_q.l17;
    assign external_interrupt_line_line19 = st_q.l19;
    assign external_interrupt_line_line20 = st_q.l20;
    assign wake_sleep = st_q.wk_sleep;
    assign wake_deepsleep = st_q.wk_low;
    assign wake_standby = st_q.wk_low;
    assign irq = st_q.irq;

    assign oif.src_sel = st_q.ctrl[CTL_SRC_LO +: 2];
    assign oif.cal_en = st_q.ctrl[CTL_CAL_OUT_EN];
    assign oif.cal_rate = st_q.ctrl[CTL_CAL_RATE];
    assign oif.pol = st_q.ctrl[CTL_POL];
    assign oif.odrain = st_q.tamp[TAMP_ODRAIN];
    assign oif.alarm_lvl = st_q.flg[FLG_ALARM];
    assign oif.wake_lvl = st_q.flg[FLG_WAKE];

    rwr_out_mux #(
        .FAST_HALF(FAST_HALF),
        .SLOW_HALF(SLOW_HALF)
    ) u_out (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .oif(oif.sink),
        .pin_o(mux_out),
        .pin_oe(mux_out_oe)
    );

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence s_clr_alarm;
        psel && penable && pwrite && paddr == OFF_STS && !st_q.slverr
            && pwdata[STS_ALARM];
    endsequence

    sequence s_idle_bus;
        !(psel && penable && pwrite);
    endsequence

    property p_set_wins;
        wakeup_evt |=> st_q.flg[FLG_WAKE];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("wakeup event lost");

    property p_clear;
        s_clr_alarm ##0 !alarm_a_evt |=> !st_q.flg[FLG_ALARM];
    endproperty
    a_clear: assert property (p_clear)
        else $error("alarm flag not cleared by write of one");

    property p_line17;
        alarm_a_evt && st_q.ctrl[CTL_ALARM_IE] ##0 s_idle_bus
            |=> external_interrupt_line_line17 && wake_sleep == (clk_src != CS_NONE
            || $past(clk_src) != CS_NONE) || clk_src != $past(clk_src);
    endproperty
    a_line17: assert property (p_line17)
        else $error("alarm event did not reach line 17");

    property p_line19;
        tamper_evt && st_q.tamp[TAMP_IE] ##0 s_idle_bus |=> external_interrupt_line_line19;
    endproperty
    a_line19: assert property (p_line19)
        else $error("tamper event did not reach line 19");

    property p_line20;
        wakeup_evt && st_q.ctrl[CTL_WAKE_IE] ##0 s_idle_bus
            |=> external_interrupt_line_line20 ##1 external_interrupt_line_line20 || !st_q.flg[FLG_WAKE];
    endproperty
    a_line20: assert property (p_line20)
        else $error("wakeup event did not reach line 20");

    property p_hs_sleep_only;
        clk_src == CS_HS_OSC && $stable(clk_src)
            |-> !wake_deepsleep && !wake_standby;
    endproperty
    a_hs_sleep_only: assert property (p_hs_sleep_only)
        else $error("fast oscillator woke a deep mode");

    property p_ls_all;
        (clk_src == CS_LS_RC || clk_src == CS_LS_XTAL) && $stable(clk_src)
            && wake_sleep |-> wake_deepsleep && wake_standby;
    endproperty
    a_ls_all: assert property (p_ls_all)
        else $error("slow clock event failed to wake deep modes");

    property p_rst_vals;
        $past(sys_rst) |-> st_q.date == RST_DATE && st_q.div == RST_DIV
            && st_q.wat == RST_WAT && st_q.tsdt == RST_TSDT && !irq;
    endproperty
    a_rst_vals: assert property (p_rst_vals)
        else $error("reset values wrong");

    property p_half_day;
        !st_q.ctrl[CTL_HOUR_MODE] |-> !st_q.tim[TIME_HALF_DAY];
    endproperty
    a_half_day: assert property (p_half_day)
        else $error("half-day bit set in 24-hour format");

    property p_wday;
        st_q.date[DATE_WDAY_LO +: 3] != 3'h0;
    endproperty
    a_wday: assert property (p_wday)
        else $error("weekday zero stored");
endmodule
`default_nettype wire

// ==== bench/rwr_partner.sv ====
/* rwr_partner: interrupt controller stand-in that counts rising edges
   on the three clock interrupt lines.
   assumes the lines are registered levels on core_clk.
*/
`default_nettype none
module rwr_partner (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [2:0] lines,
    output logic [2:0][7:0] cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] prev_q;
    // only edges count: a level held high raises one request
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prev_q <= '0;
            cnt <= '0;
        end else begin
            prev_q <= lines;
            for (int k = 0; k < 3; k++) begin
                if (lines[k] && !prev_q[k]) begin
                    cnt[k] <= cnt[k] + 8'h01;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ==== bench/rwr_top_tb.sv ====
/* rwr_top_tb: self-checking bench for the calendar output and wakeup
   register block, APB reads checked from a queue of expected words.
   assumes shortened divider halves of 4 and 8 core cycles.
*/
`default_nettype none
module rwr_top_tb import rwr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic [3:0] evs = 4'h0;
    logic [1:0] clk_src = 2'h0;
    logic [31:0] prdata;
    logic pready, pslverr, mux_out, mux_out_oe, irq;
    logic external_interrupt_line_line17, external_interrupt_line_line19, external_interrupt_line_line20;
    logic wake_sleep, wake_deepsleep, wake_standby;
    logic [2:0][7:0] cnt;
    logic [32:0] exp_q[$];
    logic [31:0] rnd;
    int n_mismatch = 0;
    int n_compared = 0;
    integer seed = 32'h7EE1;
    int sb[4] = '{STS_ALARM, STS_WAKE, STS_STAMP, STS_TAMPER};
    logic [7:0] ra[9] = '{OFF_TIME, OFF_DATE, OFF_CTRL, OFF_STS, OFF_DIV,
        OFF_WAT, OFF_TSDT, OFF_ALA, OFF_BKP_FIRST};
    logic [31:0] rv[9] = '{32'h0, 32'h0000_2101, 32'h0, 32'h0000_0007,
        32'h007F_00FF, 32'h0000_FFFF, 32'h0000_000D, 32'h0, 32'h0};

    rwr_top #(.FAST_HALF(CAL_CNT_W'(4)), .SLOW_HALF(CAL_CNT_W'(8)))
    rwr_top_i (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .alarm_a_evt(evs[0]), .wakeup_evt(evs[1]),
        .stamp_evt(evs[2]), .tamper_evt(evs[3]), .clk_src(clk_src),
        .mux_out(mux_out), .mux_out_oe(mux_out_oe),
        .external_interrupt_line_line17(external_interrupt_line_line17), .external_interrupt_line_line19(external_interrupt_line_line19),
        .external_interrupt_line_line20(external_interrupt_line_line20), .wake_sleep(wake_sleep),
        .wake_deepsleep(wake_deepsleep), .wake_standby(wake_standby),
        .irq(irq));
    rwr_partner rwr_partner_i (.core_clk(core_clk), .sys_rst(sys_rst),
        .lines({external_interrupt_line_line20, external_interrupt_line_line19, external_interrupt_line_line17}), .cnt(cnt));

    always #12.5 core_clk = ~core_clk;

    task automatic stop_test;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // whole-word transfers only; a short strobe is a refusal case
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] s,
                       input logic [32:0] e);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        exp_q.push_back(e);
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_mismatch++;
            stop_test();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'hF, 33'h0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, 4'hF, {1'b0, e});
    endtask

    // write data is not returned, so writes compare a zero word
    always @(posedge core_clk) begin
        if (psel && penable && pready === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk(33'h1_FFFF_FFFF, 33'h0);
            end else begin
                chk({pslverr, pwrite ? 32'h0 : prdata}, exp_q.pop_front());
            end
        end
    end

    task automatic pulse(input logic [3:0] v, input logic [1:0] src);
        @(posedge core_clk);
        clk_src <= src;
        evs <= v;
        @(posedge core_clk);
        evs <= 4'h0;
    endtask

    task automatic evt(input int i, input logic [1:0] src, input logic ie);
        logic [2:0] ln;
        logic lp;
        ln = ie ? ((i == 0) ? 3'h1 : ((i == 1) ? 3'h4 : 3'h2)) : 3'h0;
        // wake requests follow the enabled interrupt lines only
        lp = ie && (src == CS_LS_XTAL || src == CS_LS_RC);
        pulse(4'(1 << i), src);
        #1;
        chk(33'({external_interrupt_line_line20, external_interrupt_line_line19, external_interrupt_line_line17}), 33'(ln));
        chk(33'({wake_sleep, wake_deepsleep, wake_standby}),
            33'({ie && src != CS_NONE, lp, lp}));
        chk(33'(irq), 33'(ie));
        rd(OFF_STS, 32'h7 | (32'h1 << sb[i]));
        wr(OFF_STS, 32'h0000_2D00);
        repeat (2) @(posedge core_clk);
        #1;
        chk(33'({external_interrupt_line_line20, external_interrupt_line_line19, external_interrupt_line_line17, irq}), 33'h0);
    endtask

    // first high phase after a rate change may be partial, so skip it
    task automatic half(input int len);
        int n;
        for (int r = 0; r < 2; r++) begin
            n = 0;
            while (mux_out !== 1'b1 && n < 100) begin
                @(posedge core_clk);
                n++;
            end
            if (n >= 100) begin
                n_mismatch++;
                stop_test();
            end
            n = 0;
            while (mux_out === 1'b1 && n < 100) begin
                @(posedge core_clk);
                n++;
            end
            if (n >= 100) begin
                n_mismatch++;
                stop_test();
            end
        end
        chk(33'(n), 33'(len));
        chk(33'(mux_out_oe), 33'h1);
    endtask

    task automatic pin(input logic act, input logic p, input logic od);
        logic lvl;
        lvl = act ^ p;
        chk(33'({mux_out, mux_out_oe}),
            od ? {31'h0, 1'b0, !lvl} : {31'h0, lvl, 1'b1});
    endtask

    initial begin
        repeat (5) @(posedge core_clk);
        sys_rst <= 1'b0;
        for (int k = 0; k < 9; k++) begin
            rd(ra[k], rv[k]);
        end
        apb(1'b0, 8'h18, 32'h0, 4'hF, {1'b1, 32'h0});
        apb(1'b0, 8'h02, 32'h0, 4'hF, {1'b1, 32'h0});
        apb(1'b1, OFF_BKP_FIRST, 32'hFFFF_FFFF, 4'h3, {1'b1, 32'h0});
        rd(OFF_BKP_FIRST, 32'h0);
        for (int k = 0; k < BKP_WORDS; k++) begin
            rnd = $random(seed);
            wr(OFF_BKP_FIRST + 8'(4 * k), rnd);
            rd(OFF_BKP_FIRST + 8'(4 * k), rnd);
        end
        wr(OFF_TIME, 32'h0052_3456);
        rd(OFF_TIME, 32'h0012_3456);
        wr(OFF_CTRL, 32'h0000_0040);
        wr(OFF_TIME, 32'h0051_2345);
        rd(OFF_TIME, 32'h0051_2345);
        wr(OFF_DATE, 32'h0099_1231);
        rd(OFF_DATE, 32'h0099_3231);
        wr(OFF_DATE, 32'h0099_F231);
        rd(OFF_DATE, 32'h0099_F231);
        wr(OFF_CTRL, 32'h0000_D000);
        wr(OFF_TAMP, 32'h0000_0004);
        wr(OFF_MASK, 32'h0000_2D00);
        for (int s = 0; s < 4; s++) begin
            for (int i = 0; i < 4; i++) begin
                evt(i, 2'(s), 1'b1);
            end
        end
        wr(OFF_CTRL, 32'h0);
        wr(OFF_TAMP, 32'h0);
        wr(OFF_MASK, 32'h0);
        for (int i = 0; i < 4; i++) begin
            evt(i, CS_LS_RC, 1'b0);
        end
        chk(33'(cnt), 33'h04_08_04);
        chk(33'({mux_out, mux_out_oe}), 33'h0);
        wr(OFF_CTRL, 32'h0080_0000);
        half(4);
        wr(OFF_CTRL, 32'h0088_0000);
        half(8);
        for (int s = 1; s < 4; s++) begin
            for (int p = 0; p < 2; p++) begin
                for (int od = 0; od < 2; od++) begin
                    wr(OFF_TAMP, 32'(od) << TAMP_ODRAIN);
                    wr(OFF_CTRL, (32'(s) << CTL_SRC_LO) | (32'(p) << CTL_POL));
                    pulse((s == 3) ? 4'h2 : 4'h1, CS_LS_RC);
                    repeat (2) @(posedge core_clk);
                    #1;
                    pin(s != 2, 1'(p), 1'(od));
                    wr(OFF_STS, 32'h0000_2D00);
                    repeat (3) @(posedge core_clk);
                    #1;
                    pin(1'b0, 1'(p), 1'(od));
                end
            end
        end
        stop_test();
    end
endmodule
`default_nettype wire
